/* hw/pes_irq_status.sv */
// Purpose: done, late-target and interrupt flags of the pin event units
// Assumes: unit event inputs are one-cycle pulses on clk; register port is synchronous
// Notes: read data arrive one cycle after reg_rd, marked by reg_rvalid
`timescale 1ns/100ps
`include "pes_cfg.svh"
module pes_irq_status
   import pes_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // management register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire pes_addr_t reg_addr,
   input wire pes_word_t reg_wdata,
   output pes_word_t reg_rdata,
   output logic reg_rvalid,
   // event output units
   input wire pes_tou_t host_notify_enable,
   input wire pes_tou_t tou_fire,
   input wire pes_tou_t tou_late,
   input wire pes_tou_t tou_en_wr,
   input wire pes_tou_t tou_en_wdata,
   output pes_tou_t event_output_unit_en,
   // input capture units, pin events only
   input wire pes_cap_t capture_irq_enable,
   input wire pes_cap_t cap_event,
   // global pin event interrupt status
   output logic pin_irq
);
   pes_flag_if #(.W(3)) done_f();
   pes_flag_if #(.W(3)) err_f();
   pes_flag_if #(.W(3)) tirq_f();
   pes_flag_if #(.W(2)) cirq_f();

   logic wr_res;
   logic wr_irq;
   pes_tou_t done_set;
   pes_tou_t err_set;
   pes_tou_t en_zero_wr;
   pes_cap_t cap_set;
   pes_tou_t en_q;
   pes_word_t rdata_q;
   logic rvalid_q;

   assign wr_res = reg_wr && (reg_addr == `PES_RES_OFS);
   assign wr_irq = reg_wr && (reg_addr == `PES_IRQ_OFS);

   assign done_set = tou_fire & host_notify_enable;
   assign err_set = tou_late & host_notify_enable;
   assign en_zero_wr = tou_en_wr & ~tou_en_wdata;
   // egress timestamp events have no input here by design
   assign cap_set = cap_event & capture_irq_enable;

   assign done_f.set = done_set;
   assign done_f.clr = wr_res ? reg_wdata[`PES_DONE_MSB:`PES_DONE_LSB] : 3'h0;
   assign err_f.set = err_set;
   assign err_f.clr = en_zero_wr |
      (wr_res ? reg_wdata[`PES_TRIG_MSB:`PES_TRIG_LSB] : 3'h0);
   // both done and late raise the unit interrupt, each already notify-gated
   assign tirq_f.set = done_set | err_set;
   assign tirq_f.clr = wr_irq ? reg_wdata[`PES_TRIG_MSB:`PES_TRIG_LSB] : 3'h0;
   assign cirq_f.set = cap_set;
   assign cirq_f.clr = wr_irq ? reg_wdata[`PES_CAP_MSB:`PES_CAP_LSB] : 2'h0;

   pes_flag_bank #(.W(3)) u_done (.clk(clk), .reset_n(reset_n), .f(done_f));
   pes_flag_bank #(.W(3)) u_err (.clk(clk), .reset_n(reset_n), .f(err_f));
   pes_flag_bank #(.W(3)) u_tirq (.clk(clk), .reset_n(reset_n), .f(tirq_f));
   pes_flag_bank #(.W(2)) u_cirq (.clk(clk), .reset_n(reset_n), .f(cirq_f));

   // enable bits; the unit's own event wins over a same-cycle write of one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         en_q <= {3{`PES_ENA_RST}};
      end else begin
         en_q <= ((en_q & ~tou_en_wr) | (tou_en_wr & tou_en_wdata)) & ~tou_fire;
      end
   end
   assign event_output_unit_en = en_q;

   // read path; unmapped addresses and reserved bits read zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h0;
      end else if (reg_rd) begin
         rdata_q <= 32'h0;
         if (reg_addr == `PES_RES_OFS) begin
            rdata_q[`PES_TRIG_MSB:`PES_TRIG_LSB] <= err_f.q;
            rdata_q[`PES_DONE_MSB:`PES_DONE_LSB] <= done_f.q;
         end else if (reg_addr == `PES_IRQ_OFS) begin
            rdata_q[`PES_TRIG_MSB:`PES_TRIG_LSB] <= tirq_f.q;
            rdata_q[`PES_CAP_MSB:`PES_CAP_LSB] <= cirq_f.q;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
      end
   end
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   // combinational from flag flops, so it follows the flags with no lag
   assign pin_irq = |{tirq_f.q, cirq_f.q};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_en_zero_only;
      (en_zero_wr != 3'h0) && (err_set == 3'h0);
   endsequence
   sequence s_res_w1c;
      wr_res && (done_set == 3'h0);
   endsequence
   sequence s_rd_res;
      reg_rd && (reg_addr == `PES_RES_OFS);
   endsequence
   sequence s_rd_irq;
      reg_rd && (reg_addr == `PES_IRQ_OFS);
   endsequence
   sequence s_rd_other;
      reg_rd && (reg_addr != `PES_RES_OFS) && (reg_addr != `PES_IRQ_OFS);
   endsequence
   // a clear that meets a set is not checked here, the set must win
   sequence s_irq_w1c;
      wr_irq && (tirq_f.set == 3'h0) && (cirq_f.set == 2'h0);
   endsequence
   sequence s_err_no_clr;
      (en_zero_wr == 3'h0) && !wr_res;
   endsequence
   // two edges in reset, so the async clear has surely landed
   sequence s_in_reset;
      !reset_n ##1 !reset_n;
   endsequence

   AST_ERR_SET: assert property ((err_set != 3'h0) |=>
      ((err_f.q & $past(err_set)) == $past(err_set)))
      else $error("late target did not set error flag");
   AST_ERR_ENCLR: assert property (s_en_zero_only |=>
      ((err_f.q & $past(en_zero_wr)) == 3'h0))
      else $error("error flag kept after enable zero write");
   AST_DONE_SET: assert property ((done_set != 3'h0) |=>
      ((done_f.q & $past(done_set)) == $past(done_set)))
      else $error("done flag not set");
   AST_DONE_W1C: assert property (s_res_w1c |=>
      ((done_f.q & $past(reg_wdata[2:0])) == 3'h0))
      else $error("done flag not cleared by write one");
   AST_TIRQ_SET: assert property ((tou_late != 3'h0) && (host_notify_enable == 3'h7) |=>
      ((tirq_f.q & $past(tou_late)) == $past(tou_late)) && pin_irq)
      else $error("trigger interrupt not raised");
   AST_TIRQ_GATE: assert property (
      (tirq_f.q & ~$past(tirq_f.q) & ~$past(host_notify_enable)) == 3'h0)
      else $error("trigger interrupt raised without notify");
   AST_CIRQ_SET: assert property ((cap_set != 2'h0) |=>
      ((cirq_f.q & $past(cap_set)) == $past(cap_set)))
      else $error("capture interrupt not raised");
   AST_CIRQ_GATE: assert property (
      (cirq_f.q & ~$past(cirq_f.q) & ~$past(capture_irq_enable)) == 2'h0)
      else $error("capture interrupt raised while disabled");
   AST_GLOBAL: assert property (pin_irq == ((tirq_f.q != 3'h0) || (cirq_f.q != 2'h0)))
      else $error("global interrupt mismatch");
   AST_EN_SELFCLR: assert property ((tou_fire != 3'h0) |=>
      ((en_q & $past(tou_fire)) == 3'h0))
      else $error("enable did not self-clear");
   AST_RSVD: assert property (s_rd_res |=>
      (rdata_q[31:19] == 13'h0) && (rdata_q[15:3] == 13'h0) && reg_rvalid)
      else $error("reserved bits read nonzero");

   // flag rise, clear and hold, read-back and unit enable checks
   AST_ERR_ONLY_LATE: assert property (
      (err_f.q & ~$past(err_f.q) & ~$past(tou_late & host_notify_enable)) == 3'h0)
      else $error("error flag rose without notified late target");
   AST_ERR_W1C: assert property ((wr_res && (err_set == 3'h0)) |=>
      ((err_f.q & $past(reg_wdata[`PES_TRIG_MSB:`PES_TRIG_LSB])) == 3'h0))
      else $error("error flag not cleared by write one");
   AST_ERR_HOLD: assert property (s_err_no_clr |=>
      ((err_f.q & $past(err_f.q)) == $past(err_f.q)))
      else $error("error flag cleared without a clear");
   AST_DONE_GATE: assert property (
      (done_f.q & ~$past(done_f.q) & ~$past(tou_fire & host_notify_enable)) == 3'h0)
      else $error("done flag rose without notified output event");
   AST_RES_RD: assert property (s_rd_res |=>
      (reg_rdata == {13'h0, $past(err_f.q), 13'h0, $past(done_f.q)}))
      else $error("result flags read back wrong");
   AST_TIRQ_W1C: assert property (s_irq_w1c |=>
      ((tirq_f.q & $past(reg_wdata[`PES_TRIG_MSB:`PES_TRIG_LSB])) == 3'h0))
      else $error("trigger interrupt not cleared by write");
   AST_IRQ_HOLD: assert property (!wr_irq |=>
      ((tirq_f.q & $past(tirq_f.q)) == $past(tirq_f.q)) &&
      ((cirq_f.q & $past(cirq_f.q)) == $past(cirq_f.q)))
      else $error("interrupt flag cleared without a write");
   AST_IRQ_RD: assert property (s_rd_irq |=>
      (reg_rdata == {13'h0, $past(tirq_f.q), 14'h0, $past(cirq_f.q)}))
      else $error("interrupt flags read back wrong");
   AST_CIRQ_W1C: assert property (s_irq_w1c |=>
      ((cirq_f.q & $past(reg_wdata[`PES_CAP_MSB:`PES_CAP_LSB])) == 2'h0))
      else $error("capture interrupt not cleared by write");
   AST_CIRQ_ONLY_PIN: assert property (
      (cirq_f.q & ~$past(cirq_f.q) & ~$past(cap_event)) == 2'h0)
      else $error("capture interrupt rose without a pin event");
   AST_EN_WRITE: assert property (((tou_en_wr & tou_en_wdata & ~tou_fire) != 3'h0) |=>
      ((en_q & $past(tou_en_wr & tou_en_wdata & ~tou_fire)) ==
      $past(tou_en_wr & tou_en_wdata & ~tou_fire)))
      else $error("unit enable not set by write");
   AST_UNMAPPED_RD: assert property (s_rd_other |=>
      (reg_rdata == 32'h0) && reg_rvalid)
      else $error("unmapped read not zero");
   // explicit disable overrides the default one, so reset itself is watched
   AST_RST_CLEAR: assert property (disable iff (1'b0) s_in_reset |->
      (done_f.q == 3'h0) && (err_f.q == 3'h0) && !pin_irq && !reg_rvalid &&
      (reg_rdata == 32'h0) && (event_output_unit_en == 3'h0))
      else $error("state not cleared by reset");
endmodule

/* hw/pes_cfg.svh */
// Purpose: offsets, field positions and reset values of the pin event status block
// Assumes: byte addresses on the management register port
// Notes: definitions only
`ifndef PES_CFG_SVH
`define PES_CFG_SVH
`define PES_RES_OFS 16'h0524
`define PES_IRQ_OFS 16'h0528
`define PES_TRIG_LSB 16
`define PES_TRIG_MSB 18
`define PES_DONE_LSB 0
`define PES_DONE_MSB 2
`define PES_CAP_LSB 0
`define PES_CAP_MSB 1
`define PES_FLAG_RST 1'b0
`define PES_ENA_RST 1'b0
`endif

/* hw/pes_pkg.sv */
// Purpose: shared types of the pin event status block
// Assumes: three output units, two capture units
// Notes: none
package pes_pkg;
   typedef logic [15:0] pes_addr_t;
   typedef logic [31:0] pes_word_t;
   typedef logic [2:0] pes_tou_t;
   typedef logic [1:0] pes_cap_t;
endpackage

/* hw/pes_flag_if.sv */
// Purpose: carrier between a sticky flag bank and its user
// Assumes: one clock domain
// Notes: set and clear are per-bit one-cycle pulses
`timescale 1ns/100ps
interface pes_flag_if #(parameter int W = 3);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] q;
   modport bank (input set, input clr, output q);
   modport user (output set, output clr, input q);
endinterface

/* hw/pes_flag_bank.sv */
// Purpose: bank of sticky flags, set by hardware, cleared by software
// Assumes: set and clr come from logic on clk
// Notes: a set in the same cycle as a clear wins, so no event is lost
`timescale 1ns/100ps
`include "pes_cfg.svh"
module pes_flag_bank
   import pes_pkg::*;
#(
   parameter int W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // flags
   pes_flag_if.bank f
);
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic flag_q;
      logic flag_d;
      always_comb begin
         flag_d = f.set[i] | (flag_q & ~f.clr[i]);
      end
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            flag_q <= `PES_FLAG_RST;
         end else begin
            flag_q <= flag_d;
         end
      end
      assign f.q[i] = flag_q;
   end
endmodule

/* dv/pes_unit_model.sv */
// Purpose: stand-in for the event output and input capture units
// Assumes: pulses launched just after the rising clock edge
// Notes: every event is a one-cycle pulse, as the units give them
`timescale 1ns/100ps
module pes_unit_model
   import pes_pkg::*;
(
   // clock
   input wire logic clk,
   // unit events
   output pes_tou_t tou_fire,
   output pes_tou_t tou_late,
   output pes_cap_t cap_event
);
   initial begin
      tou_fire = 3'h0;
      tou_late = 3'h0;
      cap_event = 2'h0;
   end
   // pin capture only; egress timestamps never reach this port
   task automatic pulse(input pes_tou_t f, input pes_tou_t l, input pes_cap_t c);
      tou_fire = f;
      tou_late = l;
      cap_event = c;
      @(posedge clk);
      #1;
      tou_fire = 3'h0;
      tou_late = 3'h0;
      cap_event = 2'h0;
   endtask
endmodule

/* dv/tb_pes_irq_status.sv */
// Purpose: register-level tests of the pin event status block
// Assumes: inputs driven 1 ns after the rising edge
// Notes: read data checked one cycle after the read strobe
`timescale 1ns/100ps
`include "pes_cfg.svh"
module tb_pes_irq_status
   import pes_pkg::*;
;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, pin_irq;
   pes_addr_t reg_addr = 16'h0000;
   pes_word_t reg_wdata = 32'h00000000, reg_rdata;
   pes_tou_t host_notify_enable = 3'h0, tou_en_wr = 3'h0, tou_en_wdata = 3'h0;
   pes_tou_t tou_fire, tou_late, event_output_unit_en;
   pes_cap_t capture_irq_enable = 2'h0, cap_event;
   int err_count = 0, cmp_count = 0;
   always #4 clk = ~clk;
   pes_unit_model m (.clk(clk), .tou_fire(tou_fire), .tou_late(tou_late), .cap_event(cap_event));
   pes_irq_status uut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .host_notify_enable(host_notify_enable),
      .tou_fire(tou_fire), .tou_late(tou_late), .tou_en_wr(tou_en_wr),
      .tou_en_wdata(tou_en_wdata), .event_output_unit_en(event_output_unit_en),
      .capture_irq_enable(capture_irq_enable), .cap_event(cap_event), .pin_irq(pin_irq));
   task automatic chk(input string n, input pes_word_t e, input pes_word_t g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic rd(input pes_addr_t a, input pes_word_t e, input string n);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      chk("rvalid", 32'h00000001, {31'h00000000, reg_rvalid});
      chk(n, e, reg_rdata);
   endtask
   task automatic wr(input pes_addr_t a, input pes_word_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic en_wr(input pes_tou_t s, input pes_tou_t v);
      tou_en_wr = s;
      tou_en_wdata = v;
      @(posedge clk);
      #1;
      tou_en_wr = 3'h0;
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // no handshake waits exist, so one bounded watchdog covers the run
   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b1;
      rd(`PES_RES_OFS, 32'h00000000, "result flags");
      rd(`PES_IRQ_OFS, 32'h00000000, "irq flags");
      $display("test reset done");
      host_notify_enable = 3'h6;
      capture_irq_enable = 2'h1;
      en_wr(3'h4, 3'h4);
      chk("unit enable", 32'h00000004, {29'h0, event_output_unit_en});
      m.pulse(3'h4, 3'h3, 2'h3);
      chk("unit enable", 32'h00000000, {29'h0, event_output_unit_en});
      chk("pin_irq", 32'h00000001, {31'h0, pin_irq});
      rd(`PES_RES_OFS, 32'h00020004, "result flags");
      rd(`PES_IRQ_OFS, 32'h00060001, "irq flags");
      rd(16'h0520, 32'h00000000, "unmapped");
      $display("test set done");
      wr(`PES_RES_OFS, 32'hFFF80004);
      rd(`PES_RES_OFS, 32'h00020000, "result flags");
      en_wr(3'h2, 3'h0);
      rd(`PES_RES_OFS, 32'h00000000, "result flags");
      wr(`PES_IRQ_OFS, 32'h00040001);
      rd(`PES_IRQ_OFS, 32'h00020000, "irq flags");
      chk("pin_irq", 32'h00000001, {31'h0, pin_irq});
      wr(`PES_IRQ_OFS, 32'hFFFFFFFF);
      chk("pin_irq", 32'h00000000, {31'h0, pin_irq});
      rd(`PES_IRQ_OFS, 32'h00000000, "irq flags");
      $display("test clear done");
      en_wr(3'h1, 3'h1);
      m.pulse(3'h1, 3'h1, 2'h2);
      chk("unit enable", 32'h00000000, {29'h0, event_output_unit_en});
      chk("pin_irq", 32'h00000000, {31'h0, pin_irq});
      rd(`PES_RES_OFS, 32'h00000000, "result flags");
      rd(`PES_IRQ_OFS, 32'h00000000, "irq flags");
      $display("test gate done");
      host_notify_enable = 3'h7;
      capture_irq_enable = 2'h3;
      tou_en_wr = 3'h1;
      tou_en_wdata = 3'h0;
      m.pulse(3'h0, 3'h5, 2'h2);
      tou_en_wr = 3'h0;
      rd(`PES_RES_OFS, 32'h00050000, "result flags");
      rd(`PES_IRQ_OFS, 32'h00050002, "irq flags");
      wr(`PES_RES_OFS, 32'h00010000);
      rd(`PES_RES_OFS, 32'h00040000, "result flags");
      rd(`PES_IRQ_OFS, 32'h00050002, "irq flags");
      chk("pin_irq", 32'h00000001, {31'h0, pin_irq});
      $display("test error clear done");
      en_wr(3'h3, 3'h3);
      chk("unit enable", 32'h00000003, {29'h0, event_output_unit_en});
      reset_n = 1'b0;
      @(posedge clk);
      #1;
      chk("pin_irq", 32'h00000000, {31'h0, pin_irq});
      chk("unit enable", 32'h00000000, {29'h0, event_output_unit_en});
      @(posedge clk);
      #1 reset_n = 1'b1;
      rd(`PES_RES_OFS, 32'h00000000, "result flags");
      rd(`PES_IRQ_OFS, 32'h00000000, "irq flags");
      $display("test reset again done");
      finish_test();
   end
endmodule
